// ===== common/mpp_pkg.sv
/*
  Shared constants and types for the motor protection and power management block:
  register map, field positions, reset values, timing figures and carrier structs.
  Assumes a 50 MHz system clock and sensor words already scaled by the front end.
*/
package mpp_pkg;
  // timing: one clock is 20 ns, delays are kept in milliseconds and seconds
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1_000_000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int PCT_STEPS = 100;
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam logic [7:0] PCT_ZERO = 8'h00;
  localparam logic [7:0] PCT_ONE = 8'h01;
  localparam logic [7:0] DRV_OVERHEAT_C = 8'h7D;
  localparam logic [15:0] CNT_SAT = 16'hFFFF;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_LIM0 = 8'h08;
  localparam logic [7:0] OFF_UV_TH = 8'h20;
  localparam logic [7:0] OFF_HOLD_PCT = 8'h24;
  localparam logic [7:0] OFF_CRED_DLY = 8'h28;
  localparam logic [7:0] OFF_POFF_DLY = 8'h2C;
  localparam logic [7:0] OFF_SMOOTH = 8'h30;
  localparam logic [7:0] OFF_CAUSE = 8'h34;
  localparam logic [7:0] OFF_IRQ_ST = 8'h38;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h3C;
  localparam logic [7:0] OFF_STATUS = 8'h40;

  // limits: entries 0..4 are maxima, entry 5 is the usb minimum voltage
  localparam int NUM_LIM = 6;
  localparam int NUM_MAX = 5;
  localparam int LIM_USB_MIN = 5;
  localparam logic [15:0] LIM_MAX_RST = 16'hFFFF;
  localparam logic [15:0] LIM_MIN_RST = 16'h0000;

  // control register bits
  localparam int CB_UV = 0;
  localparam int CB_OVHEAT = 1;
  localparam int CB_BRIDGE = 2;
  localparam int CB_MISSET = 3;
  localparam int CB_STICKY = 4;
  localparam int CB_USBREC = 5;
  localparam int CB_CRED = 6;
  localparam int CB_POFF = 7;
  localparam int CB_SMOOTH = 8;
  localparam int CTRL_W = 9;
  localparam int CMD_STOP = 0;

  // fault cause bits, 0..4 follow the limit entries
  localparam int FC_USB_LOW = 5;
  localparam int FC_UV = 6;
  localparam int FC_OVHEAT = 7;
  localparam int FC_BRIDGE = 8;
  localparam int FC_MISSET = 9;
  localparam int CAUSE_W = 10;

  // interrupt status bits
  localparam int IB_FAULT = 0;
  localparam int IB_USBRST = 1;
  localparam int IB_HOLD = 2;
  localparam int IB_OFF = 3;
  localparam int IRQ_W = 4;

  typedef struct packed {
    logic [15:0] pwr_cur;
    logic [15:0] pwr_volt;
    logic [15:0] usb_cur;
    logic [15:0] usb_volt;
    logic [15:0] board_temp;
    logic [7:0] drv_temp;
  } mpp_meas_t;

  typedef struct packed {
    logic moving;
    logic dir_right;
    logic lim_left;
    logic lim_right;
    logic bridge_alert;
    logic usb_link_ok;
  } mpp_motion_t;

  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_WAIT = 4'h2,
    ST_HOLD = 4'h4,
    ST_OFF = 4'h8
  } mpp_hold_st_t;
endpackage

// ===== hw/mpp_tick.sv
/*
  Millisecond and second tick generator for the stop delays.
  Assumes clr is held while the motor moves so counting restarts at each stop.
*/
`timescale 1ns/1ps
module mpp_tick
  import mpp_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // control
  input wire logic clr,
  // ticks
  output logic ms_tick,
  output logic s_tick
);
  typedef struct packed {
    logic [31:0] cyc;
    logic [15:0] ms;
    logic ms_tick;
    logic s_tick;
  } mpp_tick_st_t;

  mpp_tick_st_t s_q, s_d;

  // a restart drops the partial millisecond so delays never run short
  always_comb begin
    s_d = s_q;
    s_d.ms_tick = 1'b0;
    s_d.s_tick = 1'b0;
    if (clr) begin
      s_d.cyc = '0;
      s_d.ms = '0;
    end else if (s_q.cyc == 32'(CYC_PER_MS_P - 1)) begin
      s_d.cyc = '0;
      s_d.ms_tick = 1'b1;
      if (s_q.ms == 16'(MS_PER_S - 1)) begin
        s_d.ms = '0;
        s_d.s_tick = 1'b1;
      end else begin
        s_d.ms = s_q.ms + 16'h0001;
      end
    end else begin
      s_d.cyc = s_q.cyc + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ms_tick = s_q.ms_tick;
  assign s_tick = s_q.s_tick;
endmodule

// ===== hw/mpp_ramp.sv
/*
  Winding current ramp: moves the current setting one percent per step toward its
  target. Assumes the target is a percentage of nominal in the range 0..100.
*/
`timescale 1ns/1ps
module mpp_ramp
  import mpp_pkg::*;
#(
  parameter int STEP_CYC_P = CYC_PER_MS / PCT_STEPS
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // setting
  input wire logic smooth_en,
  input wire logic [15:0] smooth_ms,
  input wire logic [7:0] target,
  // output
  output logic [7:0] current_pct
);
  typedef struct packed {
    logic [7:0] cur;
    logic [31:0] cnt;
  } mpp_ramp_st_t;

  mpp_ramp_st_t s_q, s_d;
  logic [31:0] interval;

  // a full 0..100 swing takes the set time; smaller swings finish sooner
  assign interval = 32'(smooth_ms) * 32'(STEP_CYC_P);

  always_comb begin
    s_d = s_q;
    if (!smooth_en || smooth_ms == 16'h0000) begin
      s_d.cur = target;
      s_d.cnt = '0;
    end else if (s_q.cur == target) begin
      s_d.cnt = '0;
    end else if (s_q.cnt + 32'h0000_0001 >= interval) begin
      s_d.cnt = '0;
      s_d.cur = (s_q.cur < target) ? s_q.cur + PCT_ONE : s_q.cur - PCT_ONE;
    end else begin
      s_d.cnt = s_q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign current_pct = s_q.cur;

  property p_ramp_step;
    @(posedge clock) disable iff (!resetn)
    (smooth_en && smooth_ms != 16'h0000) |=> (current_pct == $past(current_pct)) ||
      (current_pct == 8'($past(current_pct) + PCT_ONE)) ||
      (current_pct == 8'($past(current_pct) - PCT_ONE));
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp jumped more than one step");

  c_ramp_move: cover property (@(posedge clock) disable iff (!resetn)
    smooth_en && smooth_ms != 16'h0000 && s_d.cur != s_q.cur);
endmodule

// ===== hw/mpp_top.sv
/*
  Motor protection and power management: fault monitor with optional latching,
  usb link recovery, hold-current reduction, power-off on stop and current
  smoothing, reached over an AHB-Lite slave with a maskable level interrupt.
  Assumes sensor words and motion flags are synchronous to clock.
*/
// How it works
// - any supply, usb or board reading out of range kills power, enters fault
// - undervoltage check on: supply at or below threshold enters fault
// - driver overheat check on: driver above 125 C enters fault
// - bridge alert check on: driver malfunction signal enters fault
// - misset check on: wrong-side limit switch during motion enters fault
// - latching off: fault clears itself once its cause disappears
// - latching on: fault and cause stay until the host stop command
// - usb recovery on: a broken link triggers a usb link reset
// - reduction on: hold current is a set percentage 0..100 of nominal
// - reduced current applies after a 0..65535 ms delay from stop
// - power-off on: windings de-energise 0..65535 s after stop
// - smoothing on: current ramps to new value over set milliseconds
`timescale 1ns/1ps
module mpp_top
  import mpp_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // measurements and motion
  input wire mpp_meas_t meas,
  input wire mpp_motion_t motion,
  // power stage
  output logic pwr_en,
  output logic fault,
  output logic winding_on,
  output logic [7:0] current_pct,
  output logic usb_reset,
  // interrupt
  output logic irq
);
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [NUM_LIM-1:0][15:0] lim;
    logic [15:0] uv_th;
    logic [7:0] hold_pct;
    logic [15:0] cred_dly;
    logic [15:0] poff_dly;
    logic [15:0] smooth_ms;
    logic [CAUSE_W-1:0] cause;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    mpp_hold_st_t st;
    logic [15:0] ms_cnt;
    logic [15:0] s_cnt;
    logic link_ok;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic fault;
    logic pwr_en;
    logic winding_on;
    logic usb_reset;
    logic irq;
  } mpp_top_st_t;

  mpp_top_st_t s_q, s_d;
  logic [NUM_MAX-1:0][15:0] max_meas;
  logic [CAUSE_W-1:0] live;
  logic ms_tick, s_tick, stop_cmd, ap_take, off_hit, red_hit;
  logic [IRQ_W-1:0] ev;
  logic [7:0] target;
  mpp_hold_st_t st_n;

  assign max_meas = {meas.board_temp, meas.usb_volt, meas.usb_cur, meas.pwr_volt, meas.pwr_cur};

  // one comparator per maximum limit
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MAX; gi++) begin : g_over
      assign live[gi] = max_meas[gi] > s_q.lim[gi];
    end
  endgenerate

  // remaining fault conditions, each gated by its enable except the usb minimum, which is always checked
  assign live[FC_USB_LOW] = meas.usb_volt < s_q.lim[LIM_USB_MIN];
  assign live[FC_UV] = s_q.ctrl[CB_UV] && meas.pwr_volt <= s_q.uv_th;
  assign live[FC_OVHEAT] = s_q.ctrl[CB_OVHEAT] && meas.drv_temp > DRV_OVERHEAT_C;
  assign live[FC_BRIDGE] = s_q.ctrl[CB_BRIDGE] && motion.bridge_alert;
  assign live[FC_MISSET] = s_q.ctrl[CB_MISSET] && motion.moving &&
    ((motion.dir_right && motion.lim_left) || (!motion.dir_right && motion.lim_right));

  // bus phases: the slave never stalls, read data is ready in the data phase
  assign ap_take = hsel && htrans[1] && hready;
  assign stop_cmd = s_q.ap_wr && s_q.ap_addr == OFF_CMD && hwdata[CMD_STOP];

  mpp_tick #(.CYC_PER_MS_P(CYC_PER_MS_P)) u_tick (
    .clock(clock),
    .resetn(resetn),
    .clr(motion.moving),
    .ms_tick(ms_tick),
    .s_tick(s_tick)
  );

  mpp_ramp #(.STEP_CYC_P(CYC_PER_MS_P / PCT_STEPS)) u_ramp (
    .clock(clock),
    .resetn(resetn),
    .smooth_en(s_q.ctrl[CB_SMOOTH]),
    .smooth_ms(s_q.smooth_ms),
    .target(target),
    .current_pct(current_pct)
  );

  // hold-current state: delays restart whenever the motor moves again
  always_comb begin
    off_hit = s_q.ctrl[CB_POFF] && s_q.s_cnt >= s_q.poff_dly;
    red_hit = s_q.ctrl[CB_CRED] && s_q.ms_cnt >= s_q.cred_dly;
    case (s_q.st)
      ST_OFF: st_n = motion.moving ? ST_RUN : ST_OFF;
      ST_RUN, ST_WAIT, ST_HOLD: begin
        if (motion.moving) begin
          st_n = ST_RUN;
        end else if (off_hit) begin
          st_n = ST_OFF;
        end else if (red_hit) begin
          st_n = ST_HOLD;
        end else begin
          st_n = ST_WAIT;
        end
      end
      default: st_n = ST_RUN;
    endcase
  end

  // current target: nothing in fault or off, hold level when reduced
  always_comb begin
    if (s_q.fault || s_q.st == ST_OFF) begin
      target = PCT_ZERO;
    end else if (s_q.st == ST_HOLD) begin
      target = s_q.hold_pct;
    end else begin
      target = PCT_FULL;
    end
  end

  always_comb begin
    s_d = s_q;
    ev = '0;
    // counters clear while moving so every stop starts from zero
    if (motion.moving) begin
      s_d.ms_cnt = '0;
      s_d.s_cnt = '0;
    end else begin
      if (ms_tick && s_q.ms_cnt != CNT_SAT) s_d.ms_cnt = s_q.ms_cnt + 16'h0001;
      if (s_tick && s_q.s_cnt != CNT_SAT) s_d.s_cnt = s_q.s_cnt + 16'h0001;
    end
    s_d.st = st_n;
    // latched mode keeps causes until stop; a cause present at stop survives
    if (s_q.ctrl[CB_STICKY]) begin
      s_d.cause = (stop_cmd ? '0 : s_q.cause) | live;
    end else begin
      s_d.cause = live;
    end
    s_d.fault = |s_d.cause;
    s_d.pwr_en = !s_d.fault;
    s_d.winding_on = !s_d.fault && s_d.st != ST_OFF;
    // usb recovery fires once on the falling edge of link health
    s_d.link_ok = motion.usb_link_ok;
    s_d.usb_reset = s_q.ctrl[CB_USBREC] && s_q.link_ok && !motion.usb_link_ok;
    ev[IB_FAULT] = s_d.fault && !s_q.fault;
    ev[IB_USBRST] = s_d.usb_reset;
    ev[IB_HOLD] = s_d.st == ST_HOLD && s_q.st != ST_HOLD;
    ev[IB_OFF] = s_d.st == ST_OFF && s_q.st != ST_OFF;
    // data-phase write
    s_d.ap_wr = ap_take && hwrite;
    s_d.ap_addr = haddr[7:0];
    if (s_q.ap_wr) begin
      case (s_q.ap_addr)
        OFF_CTRL: s_d.ctrl = hwdata[CTRL_W-1:0];
        OFF_UV_TH: s_d.uv_th = hwdata[15:0];
        OFF_HOLD_PCT: s_d.hold_pct = (hwdata[7:0] > PCT_FULL) ? PCT_FULL : hwdata[7:0];
        OFF_CRED_DLY: s_d.cred_dly = hwdata[15:0];
        OFF_POFF_DLY: s_d.poff_dly = hwdata[15:0];
        OFF_SMOOTH: s_d.smooth_ms = hwdata[15:0];
        OFF_IRQ_MASK: s_d.irq_mask = hwdata[IRQ_W-1:0];
        default: begin
          for (int i = 0; i < NUM_LIM; i++) begin
            if (s_q.ap_addr == OFF_LIM0 + 8'(4 * i)) s_d.lim[i] = hwdata[15:0];
          end
        end
      endcase
    end
    // read data is captured in the address phase; interrupt status read clears, set wins
    s_d.rdata = '0;
    s_d.irq_st = s_q.irq_st;
    if (ap_take && !hwrite) begin
      case (haddr[7:0])
        OFF_CTRL: s_d.rdata = 32'(s_q.ctrl);
        OFF_UV_TH: s_d.rdata = 32'(s_q.uv_th);
        OFF_HOLD_PCT: s_d.rdata = 32'(s_q.hold_pct);
        OFF_CRED_DLY: s_d.rdata = 32'(s_q.cred_dly);
        OFF_POFF_DLY: s_d.rdata = 32'(s_q.poff_dly);
        OFF_SMOOTH: s_d.rdata = 32'(s_q.smooth_ms);
        OFF_CAUSE: s_d.rdata = 32'(s_q.cause);
        OFF_IRQ_ST: begin
          s_d.rdata = 32'(s_q.irq_st);
          s_d.irq_st = '0;
        end
        OFF_IRQ_MASK: s_d.rdata = 32'(s_q.irq_mask);
        OFF_STATUS: s_d.rdata = {18'h00000, current_pct, s_q.st, s_q.winding_on, s_q.fault};
        default: begin
          for (int i = 0; i < NUM_LIM; i++) begin
            if (haddr[7:0] == OFF_LIM0 + 8'(4 * i)) s_d.rdata = 32'(s_q.lim[i]);
          end
        end
      endcase
    end
    s_d.irq_st = s_d.irq_st | ev;
    s_d.irq = |(s_d.irq_st & s_q.irq_mask);
  end

  // every output except the tied-off hreadyout and hresp leaves from a flip-flop
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.lim <= {LIM_MIN_RST, {NUM_MAX{LIM_MAX_RST}}};
      s_q.hold_pct <= PCT_FULL;
      s_q.st <= ST_RUN;
      s_q.link_ok <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign pwr_en = s_q.pwr_en;
  assign fault = s_q.fault;
  assign winding_on = s_q.winding_on;
  assign usb_reset = s_q.usb_reset;
  assign irq = s_q.irq;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_over_cur;
    meas.pwr_cur > s_q.lim[0] |=> fault && !pwr_en;
  endproperty
  a_over_cur: assert property (p_over_cur) else $error("over-current did not fault");

  property p_uv;
    s_q.ctrl[CB_UV] && meas.pwr_volt <= s_q.uv_th |=> fault && !pwr_en && s_q.cause[FC_UV];
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage did not fault");

  property p_ovheat;
    s_q.ctrl[CB_OVHEAT] && meas.drv_temp > DRV_OVERHEAT_C |=> fault && !winding_on;
  endproperty
  a_ovheat: assert property (p_ovheat) else $error("driver overheat did not fault");

  property p_bridge;
    s_q.ctrl[CB_BRIDGE] && motion.bridge_alert |=> s_q.cause[FC_BRIDGE] && fault;
  endproperty
  a_bridge: assert property (p_bridge) else $error("bridge alert did not fault");

  property p_misset;
    s_q.ctrl[CB_MISSET] && motion.moving && !motion.dir_right && motion.lim_right |=> fault;
  endproperty
  a_misset: assert property (p_misset) else $error("misset did not fault");

  property p_autoclear;
    !s_q.ctrl[CB_STICKY] && live == '0 |=> !fault && pwr_en;
  endproperty
  a_autoclear: assert property (p_autoclear) else $error("fault did not self clear");

  property p_sticky;
    s_q.ctrl[CB_STICKY] && !stop_cmd && fault |=> fault && ((s_q.cause & $past(s_q.cause))
      == $past(s_q.cause));
  endproperty
  a_sticky: assert property (p_sticky) else $error("latched fault lost without stop");

  property p_usbrec;
    s_q.ctrl[CB_USBREC] && $fell(motion.usb_link_ok) |-> ##1 usb_reset ##1 !usb_reset;
  endproperty
  a_usbrec: assert property (p_usbrec) else $error("usb link reset missing");

  property p_hold_level;
    s_q.st == ST_HOLD && !s_q.fault && !s_q.ctrl[CB_SMOOTH] |=> current_pct == $past(s_q.hold_pct);
  endproperty
  a_hold_level: assert property (p_hold_level) else $error("hold current wrong");

  property p_cred_time;
    s_q.st == ST_WAIT ##1 s_q.st == ST_HOLD |->
      $past(s_q.ctrl[CB_CRED]) && $past(s_q.ms_cnt) >= $past(s_q.cred_dly);
  endproperty
  a_cred_time: assert property (p_cred_time) else $error("current reduced early");

  property p_poff;
    !motion.moving && s_q.ctrl[CB_POFF] && s_q.s_cnt >= s_q.poff_dly |=> !winding_on;
  endproperty
  a_poff: assert property (p_poff) else $error("windings not powered off");

  property p_restart;
    motion.moving |=> s_q.st == ST_RUN && s_q.ms_cnt == 16'h0000 && s_q.s_cnt == 16'h0000;
  endproperty
  a_restart: assert property (p_restart) else $error("motion did not cancel delays");

  c_fault: cover property (!fault ##1 fault);
  c_hold: cover property (s_q.st == ST_WAIT ##1 s_q.st == ST_HOLD);
  c_off: cover property (s_q.st == ST_HOLD ##1 s_q.st == ST_OFF);
  c_stop_clear: cover property (s_q.ctrl[CB_STICKY] && fault && stop_cmd ##1 !fault);
endmodule

// ===== dv/mpp_drv_model.sv
/*
  Behavioural model of the power driver stage and motor windings.
  Assumes the bench supplies the readings that do not depend on the windings.
*/
`timescale 1ns/1ps
module mpp_drv_model
  import mpp_pkg::*;
(
  // from the block
  input wire logic pwr_en,
  input wire logic winding_on,
  input wire logic [7:0] current_pct,
  // bench commands
  input wire mpp_meas_t base,
  input wire logic alert_cmd,
  // readings back to the block
  output mpp_meas_t meas,
  output logic bridge_alert
);
  // supply current follows winding current, so cutting the windings relieves an overload
  always_comb begin
    meas = base;
    if (pwr_en && winding_on) begin
      meas.pwr_cur = base.pwr_cur + {4'h0, current_pct, 4'h0};
    end
  end

  // the alert is held inside the driver chip and does not drop with power
  assign bridge_alert = alert_cmd;
endmodule

// ===== dv/tb_top.sv
/*
  Self-checking bench for the protection and power block: an AHB-Lite master,
  the driver model, and a monitor comparing read data against queued notes.
  Assumes the block never stalls the bus and uses a shortened millisecond.
*/
`timescale 1ns/1ps
module tb_top;
  import mpp_pkg::*;
  localparam int CPM = 100;
  logic clock, resetn, hsel, hwrite, rd_dp, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic mv, dr, ll, lr, usb_ok, alert_cmd, bridge_alert;
  logic pwr_en, fault, winding_on, usb_reset, irq;
  logic [7:0] current_pct;
  mpp_meas_t base, meas;
  mpp_motion_t motion;
  logic [31:0] exp_q[$];
  int checked, miscompares, usb_pulses, seed;

  assign motion = {mv, dr, ll, lr, bridge_alert, usb_ok};

  mpp_top #(.CYC_PER_MS_P(CPM)) dut (.clock(clock), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .meas(meas), .motion(motion), .pwr_en(pwr_en), .fault(fault),
    .winding_on(winding_on), .current_pct(current_pct), .usb_reset(usb_reset), .irq(irq));

  mpp_drv_model u_drv (.pwr_en(pwr_en), .winding_on(winding_on),
    .current_pct(current_pct), .base(base), .alert_cmd(alert_cmd), .meas(meas),
    .bridge_alert(bridge_alert));

  task automatic print_verdict();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one single transfer; the request holds until hready is seen high
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp <= !w;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd_dp <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // raise or drop one fault source; over-range values are random but above 0x1000
  task automatic src(int k, logic on);
    logic [15:0] v;
    v = on ? ((16'h1001 | 16'($random(seed))) & 16'h1FFF) : 16'h0000;
    case (k)
      0: base.pwr_cur <= v;
      1: base.pwr_volt <= on ? v : 16'h0200;
      2: base.usb_cur <= v;
      3: base.usb_volt <= on ? v : 16'h0200;
      4: base.board_temp <= v;
      5: base.usb_volt <= on ? 16'h00FF : 16'h0200;
      6: base.pwr_volt <= on ? 16'h0100 : 16'h0200;
      7: base.drv_temp <= on ? 8'h7E : 8'h19;
      8: alert_cmd <= on;
      9: begin
        dr <= !on;
        lr <= on;
      end
      10: base.drv_temp <= on ? 8'h7D : 8'h19;
      11: ll <= on;
      default: lr <= on;
    endcase
  endtask

  // read data is judged at the edge that closes its data phase; usb pulses are counted
  always @(posedge clock) begin
    if (rd_dp && hreadyout === 1'b1) begin
      check(hrdata, exp_q.pop_front());
      check(hresp, 32'h0);
    end
    if (usb_reset === 1'b1) begin
      usb_pulses++;
    end
  end

  // free-running system clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // a hang ends the run as a failure
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    print_verdict();
  end

  // main sequence
  initial begin
    logic [31:0] e;
    seed = 86860;
    {resetn, hsel, hwrite, rd_dp, htrans, haddr, hwdata, ll, lr, alert_cmd} = '0;
    {mv, dr, usb_ok} = 3'b111;
    hsize = 3'b010;
    base = {16'h0, 16'h0200, 16'h0, 16'h0200, 16'h0, 8'h19};
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    rd(OFF_CTRL, 32'h0);
    rd(OFF_LIM0, 32'hFFFF);
    wr(OFF_HOLD_PCT, 32'hC8);
    rd(OFF_HOLD_PCT, 32'h64);
    rd(8'h80, 32'h0);
    rd(OFF_STATUS, 32'h1906);
    for (int i = 0; i < NUM_MAX; i++) begin
      wr(OFF_LIM0 + 8'(4 * i), 32'h1000);
    end
    wr(OFF_LIM0 + 8'h14, 32'h100);
    wr(OFF_UV_TH, 32'h100);
    // every source with its check enabled, then with checks disabled
    for (int p = 1; p >= 0; p--) begin
      wr(OFF_CTRL, p ? 32'hF : 32'h0);
      for (int k = 0; k < 13; k++) begin
        e = (k == 10 || k == 12 || (p == 0 && k > 5)) ? 32'h0 :
            (k == 11) ? 32'h200 : 32'h1 << k;
        src(k, 1'b1);
        repeat (3) @(posedge clock);
        check(fault, e != 0);
        check(pwr_en, e == 0);
        rd(OFF_CAUSE, e);
        src(k, 1'b0);
        repeat (3) @(posedge clock);
        rd(OFF_CAUSE, 32'h0);
      end
    end
    check(irq, 0);
    wr(OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clock);
    check(irq, 1);
    rd(OFF_IRQ_ST, 32'h1);
    repeat (2) @(posedge clock);
    check(irq, 0);
    // latched fault survives its cause and a stop given while the cause is live
    wr(OFF_CTRL, 32'h14);
    src(8, 1'b1);
    repeat (3) @(posedge clock);
    wr(OFF_CMD, 32'h1);
    rd(OFF_CAUSE, 32'h100);
    src(8, 1'b0);
    wr(OFF_CMD, 32'h0);
    rd(OFF_CAUSE, 32'h100);
    check(fault, 1);
    wr(OFF_CMD, 32'h1);
    rd(OFF_CAUSE, 32'h0);
    check(fault, 0);
    rd(OFF_IRQ_ST, 32'h1);
    // link break with recovery on, then off
    for (int p = 1; p >= 0; p--) begin
      wr(OFF_CTRL, p ? 32'h20 : 32'h0);
      usb_ok <= 1'b0;
      repeat (3) @(posedge clock);
      usb_ok <= 1'b1;
      repeat (2) @(posedge clock);
      check(usb_pulses, 1);
    end
    rd(OFF_IRQ_ST, 32'h2);
    // hold current after the reduction delay, cancelled by motion
    wr(OFF_HOLD_PCT, 32'h3C);
    wr(OFF_CRED_DLY, 32'h2);
    wr(OFF_CTRL, 32'h40);
    mv <= 1'b0;
    repeat (150) @(posedge clock);
    rd(OFF_STATUS, 32'h190A);
    repeat (120) @(posedge clock);
    rd(OFF_STATUS, 32'hF12);
    mv <= 1'b1;
    repeat (3) @(posedge clock);
    rd(OFF_STATUS, 32'h1906);
    mv <= 1'b0;
    repeat (150) @(posedge clock);
    mv <= 1'b1;
    repeat (3) @(posedge clock);
    mv <= 1'b0;
    repeat (150) @(posedge clock);
    rd(OFF_STATUS, 32'h190A);
    mv <= 1'b1;
    rd(OFF_IRQ_ST, 32'h4);
    // power-off with zero delay, then a one-second delay not yet run out
    wr(OFF_CTRL, 32'h80);
    mv <= 1'b0;
    repeat (5) @(posedge clock);
    check(winding_on, 0);
    check(pwr_en, 1);
    mv <= 1'b1;
    repeat (3) @(posedge clock);
    check(winding_on, 1);
    wr(OFF_POFF_DLY, 32'h1);
    mv <= 1'b0;
    repeat (300) @(posedge clock);
    check(winding_on, 1);
    mv <= 1'b1;
    rd(OFF_IRQ_ST, 32'h8);
    // smoothing: a fault drops the target to zero over one millisecond
    wr(OFF_SMOOTH, 32'h1);
    wr(OFF_CTRL, 32'h104);
    repeat (3) @(posedge clock);
    src(8, 1'b1);
    repeat (12) @(posedge clock);
    check(current_pct > 8'h50 && current_pct < 8'h64, 1);
    repeat (120) @(posedge clock);
    check(current_pct, 0);
    src(8, 1'b0);
    repeat (3) @(posedge clock);
    print_verdict();
  end
endmodule
